// >>> hpcs_defs.svh
// Offsets, field positions, reset values and counts of the port register bank
`ifndef HPCS_DEFS_SVH
`define HPCS_DEFS_SVH

// ==========================================================================
// Register offsets
`define HPCS_SETUP_OFF 8'h9c
`define HPCS_PORT_OFF 8'ha0
`define HPCS_IRQ_STS_OFF 8'hb0
`define HPCS_IRQ_MSK_OFF 8'hb4

// ==========================================================================
// Setup-done register fields
`define HPCS_SETUP_DONE_BIT 0

// ==========================================================================
// Port register fields
`define HPCS_TEST_MSB 19
`define HPCS_TEST_LSB 16
`define HPCS_OWNER_BIT 13
`define HPCS_POWER_BIT 12
`define HPCS_LINE_DP_BIT 11
`define HPCS_LINE_DM_BIT 10
`define HPCS_BUS_RST_BIT 8
`define HPCS_SLEEP_BIT 7
`define HPCS_RESUME_BIT 6
`define HPCS_ENABLE_BIT 2
`define HPCS_CHANGE_BIT 1
`define HPCS_PRESENT_BIT 0

// ==========================================================================
// Interrupt status fields
`define HPCS_EV_CONNECT 0
`define HPCS_EV_DISABLE 1
`define HPCS_EV_HANDOVER 2
`define HPCS_EV_NUM 3

// ==========================================================================
// Reset values
`define HPCS_SETUP_RST 1'h0
`define HPCS_OWNER_RST 1'h1
`define HPCS_TEST_RST 4'h0
`define HPCS_MSK_RST 3'h0

`endif

// >>> hpcs_pkg.sv
// Types shared by the port register bank
package hpcs_pkg;

    // ======================================================================
    // State of the register bank, except the sticky event bits and the pin synchronisers
    typedef struct packed {
        logic setup_complete_bit;
        logic companion_routing_bit;
        logic supply_switch_on;
        logic bus_reset_drive;
        logic idle_sleep_state;
        logic resume_signal;
        logic link_enabled;
        logic connect_change;
        logic connect_present;
        logic [3:0] test_mode_select;
        logic [1:0] line_level_field;
        logic [2:0] irq_mask;
        logic [31:0] rdata;
    } hpcs_state_t;

    // ======================================================================
    // Sticky event bits
    typedef struct packed {
        logic [2:0] bits;
    } hpcs_sticky_t;

endpackage

// >>> hpcs_sync2.sv
// Two-flop synchroniser for pin levels
`timescale 1ns/10ps
module hpcs_sync2 import hpcs_pkg::*; #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    // ======================================================================
    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule

// >>> hpcs_sticky.sv
// Sticky event bits, write one to clear, set wins over clear
`timescale 1ns/10ps
module hpcs_sticky import hpcs_pkg::*; #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clr_all,
    input wire logic [WIDTH-1:0] set_in,
    input wire logic [WIDTH-1:0] clr_in,
    output logic [WIDTH-1:0] sticky_out
);

    logic [WIDTH-1:0] bits_r;
    logic [WIDTH-1:0] bits_nxt;

    // ======================================================================
    // Next value
    always_comb begin
        bits_nxt = (bits_r & ~clr_in) | set_in;
    end

    // ======================================================================
    // Register
    always_ff @(posedge clk) begin
        if (!rst_b || clr_all) begin
            bits_r <= '0;
        end else begin
            bits_r <= bits_nxt;
        end
    end

    assign sticky_out = bits_r;

endmodule

// >>> hpcs_regs.sv
// Setup-done flag and root port status/control registers behind APB
//
// Summary of operation
// - Setup flag steers default port routing.
// - Port register reset by power-up or controller reset.
// - After reset: nothing connected, port disabled.
// - Port state locked until power bit set.
// - Setup flag register at 9Ch, bit 0.
// - Port register at A0h, documented field layout.
// - Flag rise clears owner; flag low forces owner.
// - Power off reads bus reset, suspend, resume, enable, change and present as zero.
// - Bus reset bit starts and ends reset.
// - Line field mirrors data line levels.
`timescale 1ns/10ps
`include "hpcs_defs.svh"
module hpcs_regs import hpcs_pkg::*; #(
    parameter int ADDR_W = 8,
    parameter bit HAS_PWR_CTL = 1'b1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hc_reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dp_pin,
    input wire logic dm_pin,
    input wire logic attach_pin,
    output logic setup_complete_bit,
    output logic companion_routing_bit,
    output logic supply_switch_on,
    output logic bus_reset_drive,
    output logic idle_sleep_state,
    output logic resume_signal,
    output logic link_enabled,
    output logic [3:0] test_mode_select,
    output logic irq
);

    // ======================================================================
    // Declarations
    hpcs_state_t st_r;
    hpcs_state_t st_nxt;
    hpcs_state_t st_rst;
    logic [2:0] pins_sync;
    logic dp_s;
    logic dm_s;
    logic attach_s;
    logic [`HPCS_EV_NUM-1:0] ev_set;
    logic [`HPCS_EV_NUM-1:0] ev_clr;
    logic [`HPCS_EV_NUM-1:0] ev_sts;
    logic wr_acc;
    logic rd_setup;
    logic hit_setup;
    logic hit_port;
    logic hit_sts;
    logic hit_msk;
    logic hit_any;
    logic port_unlocked;
    logic owner_writable;
    logic [31:0] port_view;
    logic [31:0] setup_view;
    logic pr_end;
    logic disconnect;
    logic attach_edge;
    logic wr_setup;
    logic wr_port;
    logic wr_sts;
    logic wr_msk;
    logic fld_power;
    logic fld_owner;
    logic [3:0] fld_test;
    logic fld_bus_rst;
    logic fld_sleep;
    logic fld_resume;
    logic fld_enable;
    logic fld_change;

    // ======================================================================
    // Reset image
    always_comb begin
        st_rst = '0;
        // Owner is the only field that leaves reset set
        st_rst.setup_complete_bit = `HPCS_SETUP_RST;
        st_rst.companion_routing_bit = `HPCS_OWNER_RST;
        st_rst.supply_switch_on = 1'h0;
        st_rst.bus_reset_drive = 1'h0;
        st_rst.idle_sleep_state = 1'h0;
        st_rst.resume_signal = 1'h0;
        // Nothing attached until the pins say otherwise, port disabled until a bus reset ends
        st_rst.link_enabled = 1'h0;
        st_rst.connect_change = 1'h0;
        st_rst.connect_present = 1'h0;
        st_rst.test_mode_select = `HPCS_TEST_RST;
        st_rst.line_level_field = 2'h0;
        st_rst.irq_mask = `HPCS_MSK_RST;
        st_rst.rdata = 32'h0000_0000;
    end

    // ======================================================================
    // Pin synchronisers
    hpcs_sync2 #(
        .WIDTH(3)
    ) u_pin_sync (
        .clk(clk),
        .rst_b(rst_b),
        .async_in({dp_pin, dm_pin, attach_pin}),
        .sync_out(pins_sync)
    );

    assign dp_s = pins_sync[2];
    assign dm_s = pins_sync[1];
    assign attach_s = pins_sync[0];

    // ======================================================================
    // Address decode
    assign hit_setup = (paddr == ADDR_W'(`HPCS_SETUP_OFF));
    assign hit_port = (paddr == ADDR_W'(`HPCS_PORT_OFF));
    assign hit_sts = (paddr == ADDR_W'(`HPCS_IRQ_STS_OFF));
    assign hit_msk = (paddr == ADDR_W'(`HPCS_IRQ_MSK_OFF));
    assign hit_any = hit_setup | hit_port | hit_sts | hit_msk;
    assign wr_acc = psel & penable & pwrite & hit_any;
    // Read data is latched in setup so the access phase needs no wait
    assign rd_setup = psel & ~penable & ~pwrite;
    assign wr_setup = wr_acc & hit_setup;
    assign wr_port = wr_acc & hit_port;
    assign wr_sts = wr_acc & hit_sts;
    assign wr_msk = wr_acc & hit_msk;

    // ======================================================================
    // Port write fields
    assign fld_power = pwdata[`HPCS_POWER_BIT];
    assign fld_owner = pwdata[`HPCS_OWNER_BIT];
    assign fld_test = pwdata[`HPCS_TEST_MSB:`HPCS_TEST_LSB];
    assign fld_bus_rst = pwdata[`HPCS_BUS_RST_BIT];
    assign fld_sleep = pwdata[`HPCS_SLEEP_BIT];
    assign fld_resume = pwdata[`HPCS_RESUME_BIT];
    assign fld_enable = pwdata[`HPCS_ENABLE_BIT];
    assign fld_change = pwdata[`HPCS_CHANGE_BIT];

    // ======================================================================
    // Register views
    always_comb begin
        setup_view = 32'h0000_0000;
        setup_view[`HPCS_SETUP_DONE_BIT] = st_r.setup_complete_bit;
    end

    always_comb begin
        port_view = 32'h0000_0000;
        port_view[`HPCS_TEST_MSB:`HPCS_TEST_LSB] = st_r.test_mode_select;
        port_view[`HPCS_OWNER_BIT] = st_r.companion_routing_bit;
        port_view[`HPCS_POWER_BIT] = st_r.supply_switch_on;
        port_view[`HPCS_LINE_DP_BIT] = st_r.line_level_field[1];
        port_view[`HPCS_LINE_DM_BIT] = st_r.line_level_field[0];
        if (st_r.supply_switch_on) begin
            port_view[`HPCS_BUS_RST_BIT] = st_r.bus_reset_drive;
            port_view[`HPCS_SLEEP_BIT] = st_r.idle_sleep_state;
            port_view[`HPCS_RESUME_BIT] = st_r.resume_signal;
            port_view[`HPCS_ENABLE_BIT] = st_r.link_enabled;
            port_view[`HPCS_CHANGE_BIT] = st_r.connect_change;
            port_view[`HPCS_PRESENT_BIT] = st_r.connect_present;
        end
    end

    // ======================================================================
    // Write qualifiers
    // Without power control the port is always open to software
    assign port_unlocked = !HAS_PWR_CTL || st_r.supply_switch_on;
    // Owner is writable by software only while the flag is set
    assign owner_writable = st_r.setup_complete_bit;
    assign pr_end = wr_port && port_unlocked && st_r.bus_reset_drive
                    && !fld_bus_rst;
    assign disconnect = st_r.connect_present && !attach_s;
    assign attach_edge = attach_s != st_r.connect_present;

    // ======================================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        ev_set = '0;

        // Line levels follow the synchronised pins every cycle
        st_nxt.line_level_field = {dp_s, dm_s};

        // Setup-done flag
        if (wr_setup) begin
            st_nxt.setup_complete_bit = pwdata[`HPCS_SETUP_DONE_BIT];
        end

        // Port register writes
        if (wr_port) begin
            st_nxt.supply_switch_on = fld_power;
            if (owner_writable) begin
                st_nxt.companion_routing_bit = fld_owner;
            end
            if (port_unlocked) begin
                st_nxt.test_mode_select = fld_test;
                st_nxt.bus_reset_drive = fld_bus_rst;
                // Software may only disable; enabling comes from reset end
                if (!fld_enable) begin
                    st_nxt.link_enabled = 1'b0;
                end
                if (st_r.link_enabled) begin
                    st_nxt.idle_sleep_state = fld_sleep;
                end
                if (st_r.idle_sleep_state || fld_resume) begin
                    st_nxt.resume_signal = fld_resume;
                end
                // Resume finished: leave suspend
                if (st_r.resume_signal && !fld_resume) begin
                    st_nxt.idle_sleep_state = 1'b0;
                end
                if (fld_change) begin
                    st_nxt.connect_change = 1'b0;
                end
            end
        end

        // Bus reset ends: port enabled if a peripheral is still there
        if (pr_end) begin
            st_nxt.link_enabled = st_r.connect_present;
            st_nxt.idle_sleep_state = 1'b0;
            st_nxt.resume_signal = 1'b0;
        end

        // While driving reset the port is neither enabled nor suspended
        if (st_nxt.bus_reset_drive) begin
            st_nxt.link_enabled = 1'b0;
            st_nxt.idle_sleep_state = 1'b0;
        end

        // Connect tracking, set wins over a clearing write
        st_nxt.connect_present = attach_s;
        if (attach_edge) begin
            st_nxt.connect_change = 1'b1;
            ev_set[`HPCS_EV_CONNECT] = 1'b1;
        end

        // Peripheral gone: port falls back to disabled
        if (disconnect) begin
            st_nxt.link_enabled = 1'b0;
            st_nxt.idle_sleep_state = 1'b0;
            st_nxt.resume_signal = 1'b0;
            if (st_r.link_enabled) begin
                ev_set[`HPCS_EV_DISABLE] = 1'b1;
            end
        end

        // Power removed: port state collapses
        if (HAS_PWR_CTL && !st_nxt.supply_switch_on) begin
            st_nxt.link_enabled = 1'b0;
            st_nxt.idle_sleep_state = 1'b0;
            st_nxt.resume_signal = 1'b0;
            st_nxt.bus_reset_drive = 1'b0;
        end

        // Routing: flag rise hands the port over, flag low forces owner
        if (st_nxt.setup_complete_bit && !st_r.setup_complete_bit) begin
            st_nxt.companion_routing_bit = 1'b0;
            ev_set[`HPCS_EV_HANDOVER] = 1'b1;
        end
        if (!st_nxt.setup_complete_bit) begin
            st_nxt.companion_routing_bit = 1'b1;
        end

        // Interrupt mask
        if (wr_msk) begin
            st_nxt.irq_mask = pwdata[`HPCS_EV_NUM-1:0];
        end

        // Read data, unmapped addresses read zero
        if (rd_setup) begin
            st_nxt.rdata = 32'h0000_0000;
            if (hit_setup) begin
                st_nxt.rdata = setup_view;
            end
            if (hit_port) begin
                st_nxt.rdata = port_view;
            end
            if (hit_sts) begin
                st_nxt.rdata[`HPCS_EV_NUM-1:0] = ev_sts;
            end
            if (hit_msk) begin
                st_nxt.rdata[`HPCS_EV_NUM-1:0] = st_r.irq_mask;
            end
        end
    end

    // ======================================================================
    // Interrupt status
    // A clearing write never hides an event of the same cycle
    always_comb begin
        ev_clr = '0;
        if (wr_sts) begin
            ev_clr = pwdata[`HPCS_EV_NUM-1:0];
        end
    end

    hpcs_sticky #(
        .WIDTH(`HPCS_EV_NUM)
    ) u_events (
        .clk(clk),
        .rst_b(rst_b),
        .clr_all(hc_reset),
        .set_in(ev_set),
        .clr_in(ev_clr),
        .sticky_out(ev_sts)
    );

    // ======================================================================
    // State register
    // Aux-well reset: power-up reset or controller reset, nothing else
    always_ff @(posedge clk) begin
        if (!rst_b || hc_reset) begin
            st_r <= st_rst;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ======================================================================
    // Outputs
    assign prdata = st_r.rdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit_any;
    assign irq = |(ev_sts & st_r.irq_mask);
    assign setup_complete_bit = st_r.setup_complete_bit;
    assign companion_routing_bit = st_r.companion_routing_bit;
    assign supply_switch_on = st_r.supply_switch_on;
    assign bus_reset_drive = st_r.bus_reset_drive;
    assign idle_sleep_state = st_r.idle_sleep_state;
    assign resume_signal = st_r.resume_signal;
    assign link_enabled = st_r.link_enabled;
    assign test_mode_select = st_r.test_mode_select;

endmodule

// >>> hpcs_regs_props.sv
// Concurrent checks on the port register bank ports
`timescale 1ns/10ps
`include "hpcs_defs.svh"
module hpcs_regs_chk import hpcs_pkg::*; #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hc_reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic dp_pin,
    input wire logic dm_pin,
    input wire logic attach_pin,
    input wire logic setup_complete_bit,
    input wire logic companion_routing_bit,
    input wire logic supply_switch_on,
    input wire logic bus_reset_drive,
    input wire logic idle_sleep_state,
    input wire logic resume_signal,
    input wire logic link_enabled,
    input wire logic [3:0] test_mode_select,
    input wire logic irq
);
    // ==================================================================
    // Decode
    logic acc;
    logic hit;
    logic port_wr;
    logic port_on;
    assign acc = psel && penable;
    assign hit = paddr == ADDR_W'(`HPCS_SETUP_OFF) || paddr == ADDR_W'(`HPCS_PORT_OFF)
        || paddr == ADDR_W'(`HPCS_IRQ_STS_OFF) || paddr == ADDR_W'(`HPCS_IRQ_MSK_OFF);
    assign port_wr = acc && pwrite && paddr == ADDR_W'(`HPCS_PORT_OFF);
    // Writes that keep power on, so the port state is not locked
    assign port_on = port_wr && supply_switch_on && pwdata[12];

    // ==================================================================
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b || hc_reset);

    bus_answer_a: assert property (acc |-> pready && pslverr == !hit)
        else $error("bus answer wrong");
    owner_forced_a: assert property (!setup_complete_bit |-> companion_routing_bit)
        else $error("owner not forced");
    owner_clear_a: assert property ($rose(setup_complete_bit) |-> !companion_routing_bit)
        else $error("owner not cleared");
    flag_write_a: assert property (acc && pwrite && paddr == ADDR_W'(`HPCS_SETUP_OFF)
        |=> setup_complete_bit == $past(pwdata[0])) else $error("flag write lost");
    power_lock_a: assert property (!supply_switch_on |->
        !(bus_reset_drive || idle_sleep_state || resume_signal || link_enabled))
        else $error("port state without power");
    // Read data is loaded at the setup edge, so compare against the state before it
    port_read_a: assert property (acc && !pwrite && paddr == ADDR_W'(`HPCS_PORT_OFF) |->
        (prdata & 32'hfff0_c238) == 32'h0 && prdata[13:12] == $past({companion_routing_bit,
        supply_switch_on}) && ($past(supply_switch_on) || (prdata & 32'h0000_01c7) == 32'h0))
        else $error("port read wrong");
    bus_reset_a: assert property (port_on && pwdata[8] |=> bus_reset_drive && !link_enabled)
        else $error("bus reset not driven");
    enable_rise_a: assert property ($rose(link_enabled) |-> $fell(bus_reset_drive))
        else $error("enable without reset end");
    test_mode_a: assert property (port_on |=> test_mode_select == $past(pwdata[19:16]))
        else $error("test mode not written");
    reset_state_a: assert property (@(posedge clk) disable iff (1'b0)
        !rst_b || hc_reset |=> companion_routing_bit && !link_enabled && !supply_switch_on
        && !setup_complete_bit && !irq) else $error("reset state wrong");
endmodule

// >>> host_port_config_status_regs_tb.sv
// Self-checking bench of the port register bank
`timescale 1ns/10ps
module host_port_config_status_regs_tb;
    import hpcs_pkg::*;
    logic clk, rst_b, hc_reset, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic rerr, dp_pin, dm_pin, attach_pin, irq;
    logic setup_complete_bit, companion_routing_bit, supply_switch_on, bus_reset_drive;
    logic idle_sleep_state, resume_signal, link_enabled;
    logic [3:0] test_mode_select;
    int err_count, comparisons, cyc;

    hpcs_regs i_dut (.clk(clk), .rst_b(rst_b), .hc_reset(hc_reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .dp_pin(dp_pin), .dm_pin(dm_pin),
        .attach_pin(attach_pin), .setup_complete_bit(setup_complete_bit),
        .companion_routing_bit(companion_routing_bit), .supply_switch_on(supply_switch_on),
        .bus_reset_drive(bus_reset_drive), .idle_sleep_state(idle_sleep_state),
        .resume_signal(resume_signal), .link_enabled(link_enabled),
        .test_mode_select(test_mode_select), .irq(irq));

    // ==================================================================
    // Clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            $display("FAIL %0t timeout", $time);
            tally_and_finish();
        end
    end

    // ==================================================================
    // Helpers
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; ends at a falling edge so outputs have settled
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clk);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(rdat, exp);
    endtask

    // Pins pass two synchroniser flops, so allow a margin of cycles
    task pins(input logic dp, input logic dm, input logic at);
        @(posedge clk);
        dp_pin <= dp;
        dm_pin <= dm;
        attach_pin <= at;
        repeat (5) @(posedge clk);
        @(negedge clk);
    endtask

    task tally_and_finish;
        $display("Comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ==================================================================
    // Scenarios
    task t_reset_and_map;
        rd(8'h9c, 32'h0);
        rd(8'ha0, 32'h0000_2800);
        xfer(8'h98, 1'b0, 32'h0);
        chk({rdat[30:0], rerr}, 32'h1);
        xfer(8'hb8, 1'b1, 32'hffff_ffff);
        chk(rerr, 1'b1);
    endtask

    task t_power_lock;
        pins(1'b1, 1'b0, 1'b1);
        rd(8'ha0, 32'h0000_2800);
        xfer(8'ha0, 1'b1, 32'h0000_0104);
        chk(bus_reset_drive, 1'b0);
        xfer(8'ha0, 1'b1, 32'h0000_1000);
        chk(supply_switch_on, 1'b1);
        repeat (10) @(negedge clk);
        rd(8'ha0, 32'h0000_3803);
    endtask

    task t_change_irq;
        chk(irq, 1'b0);
        xfer(8'hb4, 1'b1, 32'h1);
        chk(irq, 1'b1);
        xfer(8'ha0, 1'b1, 32'h0000_1002);
        rd(8'ha0, 32'h0000_3801);
        chk(irq, 1'b1);
        xfer(8'hb0, 1'b1, 32'h1);
        chk(irq, 1'b0);
    endtask

    task t_bus_reset_and_test;
        xfer(8'ha0, 1'b1, 32'h0000_1100);
        chk({bus_reset_drive, link_enabled}, 2'b10);
        xfer(8'ha0, 1'b1, 32'h0000_1000);
        chk({bus_reset_drive, link_enabled}, 2'b01);
        xfer(8'ha0, 1'b1, 32'h0000_1084);
        chk({idle_sleep_state, resume_signal}, 2'b10);
        xfer(8'ha0, 1'b1, 32'h0000_10c4);
        chk({idle_sleep_state, resume_signal}, 2'b11);
        xfer(8'ha0, 1'b1, 32'h0000_1004);
        chk({idle_sleep_state, resume_signal, link_enabled}, 3'b001);
        xfer(8'ha0, 1'b1, 32'h0005_1004);
        chk(test_mode_select, 4'h5);
        rd(8'ha0, 32'h0005_3805);
        xfer(8'ha0, 1'b1, 32'h0000_1004);
    endtask

    task t_flag_owner;
        xfer(8'h9c, 1'b1, 32'h1);
        chk({setup_complete_bit, companion_routing_bit}, 2'b10);
        rd(8'h9c, 32'h1);
        rd(8'hb0, 32'h4);
        xfer(8'ha0, 1'b1, 32'h0000_3004);
        chk(companion_routing_bit, 1'b1);
        xfer(8'h9c, 1'b1, 32'h0);
        chk(companion_routing_bit, 1'b1);
        xfer(8'h9c, 1'b1, 32'h1);
        chk(companion_routing_bit, 1'b0);
    endtask

    task t_unplug_and_hc_reset;
        pins(1'b1, 1'b0, 1'b0);
        chk(link_enabled, 1'b0);
        rd(8'ha0, 32'h0000_1802);
        rd(8'hb0, 32'h7);
        @(posedge clk);
        hc_reset <= 1'b1;
        @(posedge clk);
        hc_reset <= 1'b0;
        @(negedge clk);
        rd(8'h9c, 32'h0);
        pins(1'b0, 1'b1, 1'b0);
        rd(8'ha0, 32'h0000_2400);
        chk(irq, 1'b0);
    endtask

    // ==================================================================
    // Main sequence
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        hc_reset = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        dp_pin = 1'b1;
        dm_pin = 1'b0;
        attach_pin = 1'b0;
        err_count = 0;
        comparisons = 0;
        cyc = 0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(negedge clk);
        t_reset_and_map();
        t_power_lock();
        t_change_irq();
        t_bus_reset_and_test();
        t_flag_owner();
        t_unplug_and_hc_reset();
        tally_and_finish();
    end
endmodule

bind hpcs_regs hpcs_regs_chk #(.ADDR_W(ADDR_W)) i_chk (.clk(clk), .rst_b(rst_b),
    .hc_reset(hc_reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dp_pin(dp_pin),
    .dm_pin(dm_pin), .attach_pin(attach_pin), .setup_complete_bit(setup_complete_bit),
    .companion_routing_bit(companion_routing_bit), .supply_switch_on(supply_switch_on),
    .bus_reset_drive(bus_reset_drive), .idle_sleep_state(idle_sleep_state),
    .resume_signal(resume_signal), .link_enabled(link_enabled),
    .test_mode_select(test_mode_select), .irq(irq));
